// ==== mie_pkg.sv ====
// Purpose: shared constants, opcodes and state layout of the executor
// Assumes: 18-bit program words, 11-bit program addresses, 8-bit data
// Notes: opcode field and table pointer layout are local choices
package mie_pkg;
   localparam int OP_HI = 17; // opcode field top bit
   localparam int OP_LO = 12; // opcode field bottom bit
   localparam int BIT_HI = 10; // bit select top bit
   localparam int BIT_LO = 8; // bit select bottom bit
   localparam int PW = 11; // program address width
   localparam logic [10:0] RESET_VECTOR = 11'h000; // first fetch address
   localparam logic [10:0] IRQ_VECTOR = 11'h004; // interrupt entry address
   localparam logic [10:0] PC_STEP = 11'h001; // program counter increment
   localparam logic [2:0] SP_STEP = 3'h1; // stack pointer step
   localparam logic [2:0] LAST_PAGE = 3'h7; // page used by final page fetch
   localparam logic [7:0] PC_LOW_ADDR = 8'h06; // data address of pc low byte
   localparam logic [3:0] BCD_MAX = 4'h9; // largest decimal digit
   localparam logic [7:0] ADJ_NONE = 8'h00; // no decimal correction
   localparam logic [7:0] ADJ_LOW = 8'h06; // low digit correction
   localparam logic [7:0] ADJ_HIGH = 8'h60; // high digit correction
   localparam logic [7:0] ADJ_BOTH = 8'h66; // both digits corrected
   localparam logic [7:0] ZERO_BYTE = 8'h00; // all bits clear
   localparam logic [7:0] ONES_BYTE = 8'hFF; // all bits set
   localparam logic [7:0] ONE_BYTE = 8'h01; // unit step
   localparam logic [1:0] REG_STATUS = 2'h0; // flags, read only
   localparam logic [1:0] REG_WORK = 2'h1; // working register, read only
   localparam logic [1:0] REG_CONTROL = 2'h2; // run control, read/write
   localparam logic [1:0] REG_PC_LOW = 2'h3; // fetch address low byte
   localparam int CTRL_RUN_BIT = 0; // core advances while set
   localparam logic CTRL_RUN_RESET = 1'b1; // core runs out of reset

   // opcode set, encoded by position
   typedef enum logic [5:0] {
      op_nop, op_move_m_to_w, op_move_w_to_m, op_move_imm, op_bit_clear,
      op_bit_set, op_unconditional_branch, op_skip_zero,
      op_zero_test_skip_transfer, op_bit_clear_skip, op_bit_set_skip,
      op_increment_skip_zero, op_decrement_skip_zero, op_increment_skip_zero_w,
      op_decrement_skip_zero_w, op_call, op_return, op_return_imm,
      op_interrupt_return, op_table_fetch_current_page,
      op_table_fetch_final_page, op_clear_byte, op_set_byte, op_watchdog_clear,
      op_swap, op_swap_w, op_halt, op_add_carry, op_add_carry_to_memory,
      op_add_m, op_add_to_memory, op_add_imm, op_and_m, op_and_to_memory,
      op_and_imm, op_invert_byte, op_invert_byte_w, op_decimal_adjust
   } mie_op_t;

   // whole state of the executor
   typedef struct packed {
      logic [17:0] ir; // instruction being executed
      logic ir_valid; // low marks a dummy cycle
      logic [10:0] ir_pc; // address of ir
      logic [10:0] pc; // fetch address
      logic [7:0] data_raddr; // data read address
      logic data_we; // data write strobe
      logic [7:0] data_waddr; // data write address
      logic [7:0] data_wdata; // data write value
      logic [7:0] working_register;
      logic carry;
      logic nibble_carry_bit;
      logic zero_flag;
      logic signed_range_exceeded;
      logic timeout_flag;
      logic powerdown_flag;
      logic global_interrupt_enable;
      logic [7:0] table_high_byte;
      logic tab_wait; // second cycle of a table fetch
      logic [7:0] tab_dest; // data address for table low part
      logic [7:0][10:0] stack; // return addresses
      logic [2:0] sp; // next free stack slot
      logic halted; // power-down state
      logic wdt_clear; // watchdog clear pulse
      logic irq_ack; // interrupt entry pulse
      logic run; // control register run bit
      logic [7:0] reg_rdata; // register port read data
   } mie_state_t;
endpackage

// ==== mie_executor.sv ====
// Purpose: executes fetched instructions against program and data memory
// Assumes: both memories read without a clock; writes land on the next edge
// Notes: one instruction per cycle, dummy cycle after flush
// Functional notes
// - taken skip costs two cycles, else one
// - writing pc low byte costs two cycles
// - branch, call, returns: two cycles, flags kept
// - table fetch splits word, two cycles
// - watchdog clear resets counter, clears powerdown, clears timeout unless a timeout arrives that cycle
// - halt stops core, sets powerdown, clears timeout unless a timeout arrives that cycle
// - add with carry updates four flags
// - plain add updates four flags
// - logical and updates only zero flag
// - call pushes next address, jumps to target
// - byte clear writes zero, flags kept
// - bit clear touches only selected bit
// - invert byte to memory or working register
// - decimal adjust corrects digits above nine
// - decimal adjust changes only carry
// - moves take one cycle, flags kept
// - bit test skips on zero or set
// - step by one, skip on zero result
// - zero test copies byte, skips on zero
// - nibble swap, flags kept
// - interrupt return pops and enables interrupts
`timescale 1ns/10ps
module mie_executor
   import mie_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   output logic [10:0] prog_addr,
   input wire logic [17:0] prog_data,
   output logic [7:0] data_raddr,
   input wire logic [7:0] data_rdata,
   output logic data_we,
   output logic [7:0] data_waddr,
   output logic [7:0] data_wdata,
   output logic [7:0] table_high_byte,
   output logic wdt_clear,
   input wire logic wdt_timeout,
   output logic timeout_flag,
   output logic powerdown_flag,
   output logic core_halted,
   input wire logic wake_event,
   input wire logic irq_req,
   output logic irq_ack,
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata
);
   mie_state_t st; // registered state
   mie_state_t next_st; // next state
   mie_op_t op; // opcode of ir
   logic go; // ir executes this cycle
   logic irq_take; // interrupt replaces ir
   logic [7:0] m; // data operand after forwarding
   logic [7:0] imm; // immediate operand
   logic [7:0] mask; // selected bit
   logic [10:0] sum; // {range, nibble, carry, byte}
   logic [7:0] res; // result byte
   logic [7:0] adj; // decimal correction
   logic wr_m; // result goes to data memory
   logic wr_w; // result goes to working register
   logic upd_z; // zero flag follows result
   logic upd_arith; // range, nibble and carry follow sum
   logic skip; // next instruction becomes dummy
   logic br; // load new fetch address
   logic [10:0] tgt; // new fetch address
   logic [2:0] sp_dec; // top of stack slot

   // one-hot mask of the selected bit
   function automatic logic [7:0] bit_mask(input logic [17:0] w);
      bit_mask = ONE_BYTE << w[BIT_HI:BIT_LO];
   endfunction

   // 8-bit add with carry in, returns flags above the sum
   function automatic logic [10:0] add8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic cin);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      add8 = {(a[7] == b[7]) && (s[7] != a[7]), h[4], s[8], s[7:0]};
   endfunction

   // state decode used by logic and checks
   assign op = mie_op_t'(st.ir[OP_HI:OP_LO]);
   assign irq_take = st.run && !st.halted && !st.tab_wait && st.ir_valid
                     && st.global_interrupt_enable && irq_req;
   assign go = st.run && !st.halted && !st.tab_wait && st.ir_valid && !irq_take;
   assign imm = st.ir[7:0];
   assign mask = bit_mask(st.ir);
   assign sp_dec = st.sp - SP_STEP;

   // operand: pc low byte, pending write, or memory
   always_comb begin
      if (st.data_raddr == PC_LOW_ADDR) begin
         m = st.ir_pc[7:0];
      end else if (st.data_we && st.data_waddr == st.data_raddr) begin
         m = st.data_wdata;
      end else begin
         m = data_rdata;
      end
   end

   // adder and decimal correction
   always_comb begin
      sum = add8(st.working_register, (op == op_add_imm) ? imm : m,
                 (op == op_add_carry || op == op_add_carry_to_memory)
                 ? st.carry : 1'b0);
      if ((st.working_register[3:0] > BCD_MAX || st.nibble_carry_bit)
          && (st.working_register[7:4] > BCD_MAX || st.carry)) begin
         adj = ADJ_BOTH;
      end else if (st.working_register[3:0] > BCD_MAX || st.nibble_carry_bit) begin
         adj = ADJ_LOW;
      end else if (st.working_register[7:4] > BCD_MAX || st.carry) begin
         adj = ADJ_HIGH;
      end else begin
         adj = ADJ_NONE;
      end
   end

   // next state
   always_comb begin
      next_st = st;
      next_st.data_we = 1'b0;
      next_st.wdt_clear = 1'b0;
      next_st.irq_ack = 1'b0;
      next_st.reg_rdata = ZERO_BYTE;
      res = ZERO_BYTE;
      wr_m = 1'b0;
      wr_w = 1'b0;
      upd_z = 1'b0;
      upd_arith = 1'b0;
      skip = 1'b0;
      br = 1'b0;
      tgt = st.pc;
      // register port
      if (reg_write && reg_addr == REG_CONTROL) begin
         next_st.run = reg_wdata[CTRL_RUN_BIT];
      end
      if (reg_read) begin
         case (reg_addr)
            REG_STATUS: begin
               next_st.reg_rdata = {st.halted, st.global_interrupt_enable,
                                    st.powerdown_flag, st.timeout_flag,
                                    st.signed_range_exceeded, st.zero_flag,
                                    st.nibble_carry_bit, st.carry};
            end
            REG_WORK: next_st.reg_rdata = st.working_register;
            REG_CONTROL: next_st.reg_rdata = {7'h00, st.run};
            REG_PC_LOW: next_st.reg_rdata = st.pc[7:0];
            default: next_st.reg_rdata = ZERO_BYTE;
         endcase
      end
      if (st.halted) begin
         // held until woken; data and registers kept
         if (wake_event) begin
            next_st.halted = 1'b0;
         end
      end else if (!st.run) begin
         // frozen by software
         next_st.halted = 1'b0;
      end else if (st.tab_wait) begin
         // table word is on prog_data; resume after held ir
         next_st.table_high_byte = prog_data[15:8];
         next_st.data_we = 1'b1;
         next_st.data_waddr = st.tab_dest;
         next_st.data_wdata = prog_data[7:0];
         next_st.pc = st.ir_pc + PC_STEP;
         next_st.tab_wait = 1'b0;
      end else begin
         // default fetch of the next word
         next_st.ir = prog_data;
         next_st.ir_valid = 1'b1;
         next_st.ir_pc = st.pc;
         next_st.pc = st.pc + PC_STEP;
         next_st.data_raddr = prog_data[7:0];
         if (irq_take) begin
            // re-run ir after the handler
            next_st.stack[st.sp] = st.ir_pc;
            next_st.sp = st.sp + SP_STEP;
            next_st.global_interrupt_enable = 1'b0;
            next_st.irq_ack = 1'b1;
            br = 1'b1;
            tgt = IRQ_VECTOR;
         end else if (st.ir_valid) begin
            case (op)
               op_move_m_to_w: begin
                  res = m;
                  wr_w = 1'b1;
               end
               op_move_w_to_m: begin
                  res = st.working_register;
                  wr_m = 1'b1;
               end
               op_move_imm: begin
                  res = imm;
                  wr_w = 1'b1;
               end
               op_bit_clear: begin
                  res = m & ~mask;
                  wr_m = 1'b1;
               end
               op_bit_set: begin
                  res = m | mask;
                  wr_m = 1'b1;
               end
               op_unconditional_branch: begin
                  br = 1'b1;
                  tgt = st.ir[PW-1:0];
               end
               op_skip_zero: skip = (m == ZERO_BYTE);
               op_zero_test_skip_transfer: begin
                  res = m;
                  wr_w = 1'b1;
                  skip = (m == ZERO_BYTE);
               end
               op_bit_clear_skip: skip = ((m & mask) == ZERO_BYTE);
               op_bit_set_skip: skip = ((m & mask) != ZERO_BYTE);
               op_increment_skip_zero, op_increment_skip_zero_w: begin
                  res = m + ONE_BYTE;
                  wr_m = (op == op_increment_skip_zero);
                  wr_w = !wr_m;
                  skip = (res == ZERO_BYTE);
               end
               op_decrement_skip_zero, op_decrement_skip_zero_w: begin
                  res = m - ONE_BYTE;
                  wr_m = (op == op_decrement_skip_zero);
                  wr_w = !wr_m;
                  skip = (res == ZERO_BYTE);
               end
               op_call: begin
                  next_st.stack[st.sp] = st.ir_pc + PC_STEP;
                  next_st.sp = st.sp + SP_STEP;
                  br = 1'b1;
                  tgt = st.ir[PW-1:0];
               end
               op_return, op_return_imm, op_interrupt_return: begin
                  next_st.sp = sp_dec;
                  br = 1'b1;
                  tgt = st.stack[sp_dec];
                  res = imm;
                  wr_w = (op == op_return_imm);
                  if (op == op_interrupt_return) begin
                     next_st.global_interrupt_enable = 1'b1;
                  end
               end
               op_table_fetch_current_page, op_table_fetch_final_page: begin
                  // fetched word is held in ir while the table word is read
                  next_st.pc = {(op == op_table_fetch_final_page) ? LAST_PAGE
                                : st.ir_pc[PW-1:8], st.working_register};
                  next_st.tab_wait = 1'b1;
                  next_st.tab_dest = st.data_raddr;
               end
               op_clear_byte: begin
                  res = ZERO_BYTE;
                  wr_m = 1'b1;
               end
               op_set_byte: begin
                  res = ONES_BYTE;
                  wr_m = 1'b1;
               end
               op_watchdog_clear: begin
                  next_st.wdt_clear = 1'b1;
                  next_st.timeout_flag = 1'b0;
                  next_st.powerdown_flag = 1'b0;
               end
               op_swap, op_swap_w: begin
                  res = {m[3:0], m[7:4]};
                  wr_m = (op == op_swap);
                  wr_w = !wr_m;
               end
               op_halt: begin
                  next_st.halted = 1'b1;
                  next_st.wdt_clear = 1'b1;
                  next_st.powerdown_flag = 1'b1;
                  next_st.timeout_flag = 1'b0;
               end
               op_add_carry, op_add_carry_to_memory: begin
                  res = sum[7:0];
                  wr_m = (op == op_add_carry_to_memory);
                  wr_w = !wr_m;
                  upd_arith = 1'b1;
                  upd_z = 1'b1;
               end
               op_add_m, op_add_to_memory, op_add_imm: begin
                  res = sum[7:0];
                  wr_m = (op == op_add_to_memory);
                  wr_w = !wr_m;
                  upd_arith = 1'b1;
                  upd_z = 1'b1;
               end
               op_and_m, op_and_to_memory, op_and_imm: begin
                  res = st.working_register & ((op == op_and_imm) ? imm : m);
                  wr_m = (op == op_and_to_memory);
                  wr_w = !wr_m;
                  upd_z = 1'b1;
               end
               op_invert_byte, op_invert_byte_w: begin
                  res = ~m;
                  wr_m = (op == op_invert_byte);
                  wr_w = !wr_m;
                  upd_z = 1'b1;
               end
               op_decimal_adjust: begin
                  res = st.working_register + adj;
                  wr_m = 1'b1;
                  next_st.carry = st.carry || adj[7:4] != 4'h0;
               end
               default: res = ZERO_BYTE;
            endcase
         end
         // common write-back
         if (wr_w) begin
            next_st.working_register = res;
         end
         if (upd_z) begin
            next_st.zero_flag = (res == ZERO_BYTE);
         end
         if (upd_arith) begin
            next_st.signed_range_exceeded = sum[10];
            next_st.nibble_carry_bit = sum[9];
            next_st.carry = sum[8];
         end
         if (wr_m && st.data_raddr == PC_LOW_ADDR) begin
            br = 1'b1;
            tgt = {st.ir_pc[PW-1:8], res};
         end else if (wr_m) begin
            next_st.data_we = 1'b1;
            next_st.data_waddr = st.data_raddr;
            next_st.data_wdata = res;
         end
         if (skip) begin
            next_st.ir_valid = 1'b0;
         end
         if (br) begin
            next_st.pc = tgt;
            next_st.ir_valid = 1'b0;
         end
      end
      // a timeout in the clearing cycle still sets the flag
      if (wdt_timeout) begin
         next_st.timeout_flag = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.pc <= RESET_VECTOR;
         st.run <= CTRL_RUN_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs come straight from state
   assign prog_addr = st.pc;
   assign data_raddr = st.data_raddr;
   assign data_we = st.data_we;
   assign data_waddr = st.data_waddr;
   assign data_wdata = st.data_wdata;
   assign table_high_byte = st.table_high_byte;
   assign wdt_clear = st.wdt_clear;
   assign timeout_flag = st.timeout_flag;
   assign powerdown_flag = st.powerdown_flag;
   assign core_halted = st.halted;
   assign irq_ack = st.irq_ack;
   assign reg_rdata = st.reg_rdata;

   // checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_skip_dummy: assert property (
      go && skip |=> !st.ir_valid ##1 !data_we)
      else $error("skipped instruction was not a dummy");
   chk_branch_bubble: assert property (
      go && op == op_unconditional_branch && !wdt_timeout
      |=> !st.ir_valid && prog_addr == $past(st.ir[PW-1:0])
          && $stable(st.carry) && $stable(st.zero_flag))
      else $error("branch did not load target with dummy");
   chk_pc_low_write: assert property (
      go && wr_m && st.data_raddr == PC_LOW_ADDR |=> !st.ir_valid && !data_we)
      else $error("pc low write did not flush");
   chk_call_push: assert property (
      go && op == op_call |=> st.stack[$past(st.sp)] == $past(st.ir_pc) + PC_STEP)
      else $error("call pushed wrong address");
   chk_table_two: assert property (
      go && op == op_table_fetch_final_page
      |=> st.tab_wait && prog_addr[10:8] == LAST_PAGE ##1 !st.tab_wait && data_we)
      else $error("table fetch sequence wrong");
   chk_watchdog_flags: assert property (
      go && op == op_watchdog_clear && !wdt_timeout
      |=> wdt_clear && !timeout_flag && !powerdown_flag)
      else $error("watchdog clear left a flag set");
   chk_halt_state: assert property (
      go && op == op_halt && !wdt_timeout
      |=> core_halted && powerdown_flag && !timeout_flag && wdt_clear)
      else $error("halt did not enter power down");
   chk_clear_zero: assert property (
      go && op == op_clear_byte && st.data_raddr != PC_LOW_ADDR
      |=> data_we && data_wdata == ZERO_BYTE && $stable(st.zero_flag))
      else $error("byte clear wrote nonzero");
   chk_and_zero: assert property (
      go && op == op_and_to_memory && st.data_raddr != PC_LOW_ADDR
      |=> data_we && st.zero_flag == (data_wdata == ZERO_BYTE) && $stable(st.carry))
      else $error("and zero flag wrong");
   chk_return_enable: assert property (
      go && op == op_interrupt_return |=> st.global_interrupt_enable && !st.ir_valid)
      else $error("interrupt return did not enable");
   chk_timeout_wins: assert property (
      wdt_timeout |=> timeout_flag)
      else $error("timeout event lost");

   cov_skip_taken: cover property (go && skip);
   cov_table_fetch: cover property (go && op == op_table_fetch_current_page);
   cov_irq_entry: cover property (irq_take);
   cov_halt_wake: cover property (core_halted && wake_event);
endmodule

// ==== mie_far_side.sv ====
// Purpose: program memory, data memory and watchdog clear counter beside the executor
// Assumes: both memories read without a clock, data writes land at the edge
// Notes: unwritten data bytes hold a pattern, never the last value
`timescale 1ns/10ps
module mie_far_side (
   input wire logic clock,
   input wire logic [10:0] prog_addr,
   output logic [17:0] prog_data,
   input wire logic [7:0] data_raddr,
   output logic [7:0] data_rdata,
   input wire logic data_we,
   input wire logic [7:0] data_waddr,
   input wire logic [7:0] data_wdata,
   input wire logic wdt_clear
);
   logic [17:0] pmem [0:2047]; // program words, filled by the bench
   logic [7:0] dmem [0:255]; // data bytes
   int wdt_pulses; // watchdog clears seen
   // memories start filled so no read ever sees an unknown
   initial begin
      wdt_pulses = 0;
      for (int i = 0; i < 2048; i++) pmem[i] = 18'h00000;
      for (int i = 0; i < 256; i++) dmem[i] = 8'(i) ^ 8'hA5;
   end
   assign prog_data = pmem[prog_addr]; // same-cycle fetch
   assign data_rdata = dmem[data_raddr]; // same-cycle read
   // write and watchdog clear both act at the edge ending the strobe
   always @(posedge clock) begin
      if (data_we) dmem[data_waddr] <= data_wdata;
      if (wdt_clear) wdt_pulses <= wdt_pulses + 1;
   end
endmodule

// ==== tb_top.sv ====
// Purpose: runs a short program through the executor and checks results
// Assumes: far side model supplies both memories
// Notes: expected bytes are worked out by hand from the instruction effects
`timescale 1ns/10ps
module tb_top;
   import mie_pkg::*;
   logic clock, rst_n, reg_write, reg_read, data_we, wdt_clear, timeout_flag;
   logic powerdown_flag, core_halted, wdt_timeout, wake_event;
   logic [1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, data_raddr, data_rdata, data_waddr, data_wdata, tbh;
   logic [10:0] prog_addr;
   logic [17:0] prog_data;
   int errors, cmp_count, cycles;
   mie_executor uut (.clock(clock), .rst_n(rst_n), .prog_addr(prog_addr),
      .prog_data(prog_data), .data_raddr(data_raddr), .data_rdata(data_rdata),
      .data_we(data_we), .data_waddr(data_waddr), .data_wdata(data_wdata),
      .table_high_byte(tbh), .wdt_clear(wdt_clear), .wdt_timeout(wdt_timeout),
      .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
      .core_halted(core_halted), .wake_event(wake_event), .irq_req(1'b0), .irq_ack(),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata));
   mie_far_side m (.clock(clock), .prog_addr(prog_addr), .prog_data(prog_data),
      .data_raddr(data_raddr), .data_rdata(data_rdata), .data_we(data_we),
      .data_waddr(data_waddr), .data_wdata(data_wdata), .wdt_clear(wdt_clear));
   // program word: opcode, spare bit, bit select, address or immediate
   function automatic logic [17:0] w(mie_op_t o, logic [2:0] b, logic [7:0] a);
      return {o, 1'b0, b, a};
   endfunction
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // one read cycle; data stands only in the following cycle
   task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask
   task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   // call at 9 reaches its target two fetch cycles later
   task automatic test_call_timing;
      int n;
      n = 0;
      while (prog_addr !== 11'h009 && n < 200) begin @(negedge clock); n++; end
      n = 0;
      while (prog_addr !== 11'h010 && n < 10) begin @(negedge clock); n++; end
      check("call cycles", 8'h02, 8'(n));
      repeat (40) @(negedge clock);
      $display("call timing done");
   endtask
   task automatic test_results;
      logic [7:0] d;
      check("clear bit", 8'hF7, m.dmem[8'h23]);
      check("and to memory", 8'h00, m.dmem[8'h20]);
      check("decimal adjust", 8'h87, m.dmem[8'h21]);
      check("byte clear", 8'h00, m.dmem[8'h28]);
      check("skipped move", 8'h5A, m.dmem[8'h22]);
      check("swap", 8'hE1, m.dmem[8'h24]);
      check("increment skip", 8'h00, m.dmem[8'h25]);
      check("skipped after inc", 8'hA5, m.dmem[8'h26]);
      check("table low", 8'h3D, m.dmem[8'h27]);
      check("table high", 8'hBC, tbh);
      check("watchdog clears", 8'h01, 8'(m.wdt_pulses));
      reg_rd(REG_WORK, d);
      check("working register", 8'h7E, d);
      reg_rd(REG_STATUS, d);
      check("flags", 8'h0E, d);
      $display("program results done");
   endtask
   // clearing run freezes the fetch address
   task automatic test_run_control;
      logic [7:0] d;
      logic [10:0] a;
      reg_wr(REG_CONTROL, 8'h00);
      reg_rd(REG_CONTROL, d);
      check("run bit", 8'h00, {7'h00, d[0]});
      a = prog_addr;
      repeat (3) @(negedge clock);
      check("held address", a[7:0], prog_addr[7:0]);
      reg_wr(REG_CONTROL, 8'h01);
      $display("run control done");
   endtask
   task automatic test_halt;
      int n;
      m.pmem[11] = w(op_halt, 3'h0, 8'h00);
      n = 0;
      while (core_halted !== 1'b1 && n < 50) begin @(negedge clock); n++; end
      check("halted", 8'h01, {7'h00, core_halted});
      check("powerdown", 8'h01, {7'h00, powerdown_flag});
      check("timeout", 8'h00, {7'h00, timeout_flag});
      // wake and a watchdog timeout in one cycle: core resumes, flag set
      @(posedge clock);
      wake_event <= 1'b1;
      wdt_timeout <= 1'b1;
      @(posedge clock);
      wake_event <= 1'b0;
      wdt_timeout <= 1'b0;
      @(negedge clock);
      check("woken", 8'h00, {7'h00, core_halted});
      check("timeout set", 8'h01, {7'h00, timeout_flag});
      $display("halt done");
   endtask
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         complete_run();
      end
   end
   initial begin
      {rst_n, reg_write, reg_read, reg_addr, reg_wdata, wdt_timeout, wake_event} = '0;
      #1;
      m.pmem[0] = w(op_move_imm, 3'h0, 8'h38);
      m.pmem[1] = w(op_add_imm, 3'h0, 8'h49);
      m.pmem[2] = w(op_move_w_to_m, 3'h0, 8'h20);
      m.pmem[3] = w(op_decimal_adjust, 3'h0, 8'h21);
      m.pmem[4] = w(op_move_imm, 3'h0, 8'h00);
      m.pmem[5] = w(op_invert_byte_w, 3'h0, 8'h20);
      m.pmem[6] = w(op_and_to_memory, 3'h0, 8'h20);
      m.pmem[7] = w(op_bit_clear_skip, 3'h0, 8'h20);
      m.pmem[8] = w(op_move_w_to_m, 3'h0, 8'h22);
      m.pmem[9] = w(op_call, 3'h0, 8'h10);
      m.pmem[10] = w(op_clear_byte, 3'h0, 8'h28);
      m.pmem[11] = w(op_unconditional_branch, 3'h0, 8'h0B);
      m.pmem[16] = w(op_bit_clear, 3'h3, 8'h23);
      m.pmem[17] = w(op_swap, 3'h0, 8'h24);
      m.pmem[18] = w(op_increment_skip_zero, 3'h0, 8'h25);
      m.pmem[19] = w(op_move_w_to_m, 3'h0, 8'h26);
      m.pmem[20] = w(op_table_fetch_final_page, 3'h0, 8'h27);
      m.pmem[21] = w(op_watchdog_clear, 3'h0, 8'h00);
      m.pmem[22] = w(op_return, 3'h0, 8'h00);
      m.pmem[11'h77E] = 18'h0BC3D;
      m.dmem[8'h22] = 8'h5A;
      m.dmem[8'h23] = 8'hFF;
      m.dmem[8'h24] = 8'h1E;
      m.dmem[8'h25] = 8'hFF;
      m.dmem[8'h26] = 8'hA5;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      test_call_timing();
      test_results();
      test_run_control();
      test_halt();
      complete_run();
   end
endmodule
